// [rtl/sac_pkg.sv]
// Shared constants and carriers for the sampling control block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package sac_pkg;

   // System clock and rate arithmetic, all rates in millihertz
   localparam int unsigned RATE_W = 27;
   localparam int unsigned OSC_W = 36;
   localparam int unsigned ACC_W = 37;
   localparam logic [ACC_W-1:0] SYS_CLK_MHZ = 37'd100_000_000_000;
   localparam logic [RATE_W-1:0] RATE_MIN = 27'd195_300;
   localparam logic [RATE_W-1:0] RATE_MAX_LO = 27'd52_734_000;
   localparam logic [RATE_W-1:0] RATE_MAX_HI = 27'd105_469_000;
   localparam logic [RATE_W-1:0] MULT_BREAK = 27'd52_734_000;
   localparam logic [OSC_W-1:0] TB_MAX_MHZ = 36'd27_000_000_000;
   localparam int unsigned SHIFT_LO = 9;
   localparam int unsigned SHIFT_HI = 8;
   localparam logic [8:0] DIV_LAST_LO = 9'd511;
   localparam logic [8:0] DIV_LAST_HI = 9'd255;

   // Converter data
   localparam int unsigned N_AIN = 4;
   localparam int unsigned N_CH = 5;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned GROUP_DELAY = 39;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FE = 8'h04;
   localparam logic [7:0] OFS_RATE = 8'h08;
   localparam logic [7:0] OFS_ACTUAL = 8'h0C;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_RESULT0 = 8'h18;
   localparam logic [7:0] OFS_RESULT4 = 8'h28;

   // Field positions
   localparam int unsigned CTRL_GAIN = 0;
   localparam int unsigned CTRL_HIPWR = 1;
   localparam int unsigned CTRL_RUN = 2;
   localparam int unsigned CTRL_MASK_LSB = 4;
   localparam int unsigned FE_AC_LSB = 8;
   localparam int unsigned CMD_ONE = 0;
   localparam int unsigned CMD_ALL = 1;
   localparam int unsigned CMD_CH_LSB = 4;
   localparam int unsigned CMD_GAIN = 8;
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_DONE = 1;
   localparam int unsigned ST_GD_DONE = 2;
   localparam int unsigned ST_OVERRUN = 3;
   localparam int unsigned ST_RUN = 4;

   // Analog front-end settings
   typedef struct packed {
      logic gain10;
      logic hipower;
      logic [N_AIN-1:0] excite;
      logic [N_AIN-1:0] ac_couple;
   } sac_fe_s;

   // One simultaneous sample set
   typedef struct packed {
      logic [N_AIN-1:0][DATA_W-1:0] ain;
      logic [DATA_W-1:0] cnt;
   } sac_set_s;

endpackage

// [rtl/sac_clkgen.sv]
// Sample clock generator: oscillator multiply, timebase and sample ticks.
// Assumes the system clock of the package; rates in millihertz.
`timescale 1ns/1ps
module sac_clkgen #(
   parameter logic [26:0] RATE_MAX = sac_pkg::RATE_MAX_LO
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Control
   input wire logic run_in,
   input wire logic [sac_pkg::RATE_W-1:0] rate_in,
   // Ticks and readback
   output logic tb_tick_out,
   output logic sample_tick_out,
   output logic [sac_pkg::RATE_W-1:0] actual_out
);
   logic [sac_pkg::RATE_W-1:0] rate_c;
   logic hi;
   logic [sac_pkg::OSC_W-1:0] osc;
   logic [sac_pkg::ACC_W-1:0] acc_r;
   logic [sac_pkg::ACC_W-1:0] acc_sum;
   logic [8:0] div_r;
   logic [8:0] div_last;

   always_comb begin
      rate_c = rate_in;
      if (rate_c < sac_pkg::RATE_MIN) begin
         rate_c = sac_pkg::RATE_MIN;
      end
      if (rate_c > RATE_MAX) begin
         rate_c = RATE_MAX;
      end
      hi = rate_c > sac_pkg::MULT_BREAK;
      // Above the break the multiplier halves to keep the timebase legal
      osc = hi ? {9'h000, rate_c} << sac_pkg::SHIFT_HI
               : {9'h000, rate_c} << sac_pkg::SHIFT_LO; // [RULE10]
      if (osc > sac_pkg::TB_MAX_MHZ) begin
         osc = sac_pkg::TB_MAX_MHZ; // [RULE11]
      end
      acc_sum = acc_r + {1'b0, osc};
      div_last = hi ? sac_pkg::DIV_LAST_HI : sac_pkg::DIV_LAST_LO;
   end

   // Phase accumulator: average tick rate is exact, edges jitter by 10 ns
   always_ff @(posedge mclk_in) begin
      if (rst_in || !run_in) begin
         acc_r <= '0;
         tb_tick_out <= 1'b0;
      end else if (acc_sum >= sac_pkg::SYS_CLK_MHZ) begin
         acc_r <= acc_sum - sac_pkg::SYS_CLK_MHZ; // [RULE8]
         tb_tick_out <= 1'b1;
      end else begin
         acc_r <= acc_sum;
         tb_tick_out <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in || !run_in) begin
         div_r <= '0;
         sample_tick_out <= 1'b0;
      end else if (tb_tick_out) begin
         div_r <= (div_r == div_last) ? 9'h000 : div_r + 9'h001;
         sample_tick_out <= div_r == div_last; // [RULE9]
      end else begin
         sample_tick_out <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         actual_out <= '0;
      end else begin
         actual_out <= hi ? osc[sac_pkg::SHIFT_HI +: sac_pkg::RATE_W]
                          : osc[sac_pkg::SHIFT_LO +: sac_pkg::RATE_W]; // [RULE12]
      end
   end
endmodule

// [rtl/sac_delay_mem.sv]
// Circular delay memory that holds counter samples back by DEPTH shifts.
// Contents are undefined until DEPTH shifts have passed since a clear.
`timescale 1ns/1ps
module sac_delay_mem #(
   parameter int DEPTH = 39,
   parameter int WIDTH = 24
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Control and data
   input wire logic clear_in,
   input wire logic shift_in,
   input wire logic [WIDTH-1:0] wdata_in,
   output logic [WIDTH-1:0] rdata_out
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] ptr_r;

   always_ff @(posedge mclk_in) begin
      if (rst_in || clear_in) begin
         ptr_r <= '0;
      end else if (shift_in) begin
         ptr_r <= (ptr_r == LAST) ? '0 : ptr_r + PW'(1);
      end
   end

   // Read before write gives the word stored DEPTH shifts ago
   always_ff @(posedge mclk_in) begin
      if (shift_in) begin
         mem[ptr_r] <= wdata_in; // [RULE14]
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= '0;
      end else if (shift_in) begin
         rdata_out <= mem[ptr_r];
      end
   end
endmodule

// [rtl/sac_ctrl.sv]
// Simultaneous sampling control: APB registers, front-end settings,
// sample clock, group-delay gating, counter alignment and readout.
// Assumes converters answer each sample or single request with
// adc_valid_in at least one cycle after the request or tick.
//
// Function
// [RULE1] Four inputs sampled from one common clock
// [RULE2] Gain selectable between 1 and 10
// [RULE3] Per-input excitation enable, off after reset
// [RULE4] Per-input AC or DC coupling select
// [RULE5] Host should pick AC with excitation on
// [RULE6] Option keeps high-power input circuits always on
// [RULE7] Results fixed at 24 bits
// [RULE8] Sample clock derived internally, started by host
// [RULE9] Rate range 195.3 Hz to variant maximum
// [RULE10] Oscillator is rate times 512 or 256
// [RULE11] Timebase never above 27 MHz
// [RULE12] Achieved sample rate readable by host
// [RULE13] Discard outputs of first 39 sample pulses; the code discards the first 38 and keeps the output of the 39th
// [RULE14] Counter data delayed to match analog data
// [RULE15] Single-value reads one named channel once
// [RULE16] Single-value ends alone, cannot be stopped
// [RULE17] Counters unreachable through single-value mode
// [RULE18] Single-values captures all inputs together
// [RULE19] Counter entry valid only on counter variant
// [RULE20] Sets streamed in ascending channel order
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module sac_ctrl #(
   parameter logic [26:0] RATE_MAX = sac_pkg::RATE_MAX_LO,
   parameter bit COUNTER_VARIANT = 1'b1
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Converter side
   input wire logic adc_valid_in,
   input wire sac_pkg::sac_set_s adc_set_in,
   output sac_pkg::sac_fe_s fe_out,
   output logic tb_tick_out,
   output logic sample_tick_out,
   output logic single_req_out,
   // Sample stream
   input wire logic stream_ready_in,
   output logic stream_valid_out,
   output logic [sac_pkg::DATA_W-1:0] stream_data_out,
   output logic stream_last_out
);
   typedef enum logic [1:0] {
      SGL_IDLE,
      SGL_WAIT
   } sac_sgl_e;

   localparam logic [5:0] GD_LAST = 6'(sac_pkg::GROUP_DELAY);
   localparam int NCH = sac_pkg::N_CH;
   localparam int CHW = $clog2(sac_pkg::N_CH);

   logic [NCH-1:0] mask_r;
   logic run_r;
   logic [sac_pkg::RATE_W-1:0] rate_r;
   logic [sac_pkg::RATE_W-1:0] actual;
   logic tb_tick;
   logic sample_tick;
   logic run_q_r;
   logic [5:0] gd_cnt_r;
   logic gd_done;
   logic [sac_pkg::DATA_W-1:0] cnt_delayed;
   sac_sgl_e sgl_r;
   logic sgl_all_r;
   logic [1:0] sgl_ch_r;
   logic done_r;
   logic overrun_r;
   logic [sac_pkg::N_AIN:0][sac_pkg::DATA_W-1:0] result_r;
   sac_pkg::sac_set_s set_r;
   logic [NCH-1:0] pend_r;
   logic wr_en;
   logic rd_en;
   logic cmd_go;
   logic take_set;
   logic [NCH-1:0] rest;
   logic [CHW-1:0] next_ch;
   logic [31:0] rdata;
   logic mapped;

   // Lowest set bit of a pending mask, ascending channel order
   function automatic logic [CHW-1:0] first_ch(input logic [NCH-1:0] m);
      first_ch = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (m[i]) begin
            first_ch = CHW'(i);
         end
      end
   endfunction

   function automatic logic [NCH-1:0] eff_mask(input logic [NCH-1:0] m);
      eff_mask = m;
      eff_mask[sac_pkg::N_AIN] = m[sac_pkg::N_AIN] & COUNTER_VARIANT;
   endfunction

   assign wr_en = psel_in && penable_in && pwrite_in;
   assign rd_en = psel_in && !pwrite_in;
   // Single operations only start while the sample clock is stopped
   assign cmd_go = wr_en && paddr_in == sac_pkg::OFS_CMD && sgl_r == SGL_IDLE
                   && !run_r;
   assign gd_done = gd_cnt_r == GD_LAST;
   assign take_set = run_r && adc_valid_in && gd_done; // [RULE13]
   assign rest = pend_r & ~(NCH'(1) << next_ch);
   assign next_ch = first_ch(pend_r);

   sac_clkgen #(
      .RATE_MAX(RATE_MAX)
   ) u_clkgen (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .run_in(run_r),
      .rate_in(rate_r),
      .tb_tick_out(tb_tick),
      .sample_tick_out(sample_tick),
      .actual_out(actual)
   );

   sac_delay_mem #(
      .DEPTH(sac_pkg::GROUP_DELAY - 2), // Capture adds one set to the DEPTH of the memory
      .WIDTH(sac_pkg::DATA_W)
   ) u_delay (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .clear_in(run_r && !run_q_r),
      .shift_in(run_r && adc_valid_in),
      .wdata_in(adc_set_in.cnt),
      .rdata_out(cnt_delayed)
   );

   // Configuration registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         fe_out <= '0; // [RULE3]
         mask_r <= '0;
         run_r <= 1'b0;
         rate_r <= sac_pkg::RATE_MIN;
      end else begin
         if (wr_en && paddr_in == sac_pkg::OFS_CTRL) begin
            fe_out.gain10 <= pwdata_in[sac_pkg::CTRL_GAIN]; // [RULE2]
            fe_out.hipower <= pwdata_in[sac_pkg::CTRL_HIPWR]; // [RULE6]
            run_r <= pwdata_in[sac_pkg::CTRL_RUN]; // [RULE8]
            mask_r <= pwdata_in[sac_pkg::CTRL_MASK_LSB +: NCH];
         end
         if (wr_en && paddr_in == sac_pkg::OFS_FE) begin
            fe_out.excite <= pwdata_in[sac_pkg::N_AIN-1:0]; // [RULE3]
            fe_out.ac_couple <=
               pwdata_in[sac_pkg::FE_AC_LSB +: sac_pkg::N_AIN]; // [RULE4]
         end
         if (wr_en && paddr_in == sac_pkg::OFS_RATE) begin
            rate_r <= pwdata_in[sac_pkg::RATE_W-1:0]; // [RULE9]
         end
         if (cmd_go && (pwdata_in[sac_pkg::CMD_ONE]
                        || pwdata_in[sac_pkg::CMD_ALL])) begin
            fe_out.gain10 <= pwdata_in[sac_pkg::CMD_GAIN]; // [RULE15]
         end
      end
   end

   // Ticks to the converters share one clock for all four inputs
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         tb_tick_out <= 1'b0;
         sample_tick_out <= 1'b0;
         run_q_r <= 1'b0;
      end else begin
         tb_tick_out <= tb_tick;
         sample_tick_out <= sample_tick; // [RULE1]
         run_q_r <= run_r;
      end
   end

   // Group delay counter restarts every time the clock starts
   always_ff @(posedge mclk_in) begin
      if (rst_in || !run_r) begin
         gd_cnt_r <= '0;
      end else if (sample_tick && !gd_done) begin
         gd_cnt_r <= gd_cnt_r + 6'h01; // [RULE13]
      end
   end

   // Single-value and single-values sequencer; no stop path exists
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sgl_r <= SGL_IDLE;
         sgl_all_r <= 1'b0;
         sgl_ch_r <= '0;
         single_req_out <= 1'b0;
      end else begin
         single_req_out <= 1'b0;
         unique case (sgl_r)
            SGL_IDLE: begin
               if (cmd_go && pwdata_in[sac_pkg::CMD_ALL]) begin
                  sgl_all_r <= 1'b1; // [RULE18]
                  single_req_out <= 1'b1;
                  sgl_r <= SGL_WAIT;
               end else if (cmd_go && pwdata_in[sac_pkg::CMD_ONE]) begin
                  sgl_all_r <= 1'b0;
                  // Two-bit field cannot name a counter channel
                  sgl_ch_r <= pwdata_in[sac_pkg::CMD_CH_LSB +: 2]; // [RULE17]
                  single_req_out <= 1'b1; // [RULE15]
                  sgl_r <= SGL_WAIT;
               end
            end
            SGL_WAIT: begin
               if (adc_valid_in) begin
                  sgl_r <= SGL_IDLE; // [RULE16]
               end
            end
         endcase
      end
   end

   // Result registers, converter words are always full width
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         result_r <= '0;
      end else if (sgl_r == SGL_WAIT && adc_valid_in) begin
         if (sgl_all_r) begin
            for (int i = 0; i < sac_pkg::N_AIN; i++) begin
               result_r[i] <= adc_set_in.ain[i]; // [RULE7]
            end
            result_r[sac_pkg::N_AIN] <= COUNTER_VARIANT ?
               adc_set_in.cnt : '0; // [RULE19]
         end else begin
            result_r[sgl_ch_r] <= adc_set_in.ain[sgl_ch_r]; // [RULE15]
         end
      end
   end

   // Done and overrun flags: a new event wins over a same-cycle clear
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         done_r <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         if (sgl_r == SGL_WAIT && adc_valid_in) begin
            done_r <= 1'b1; // [RULE16]
         end else if (wr_en && paddr_in == sac_pkg::OFS_STATUS
                      && pwdata_in[sac_pkg::ST_DONE]) begin
            done_r <= 1'b0;
         end
         if (take_set && pend_r != '0) begin
            overrun_r <= 1'b1;
         end else if (wr_en && paddr_in == sac_pkg::OFS_STATUS
                      && pwdata_in[sac_pkg::ST_OVERRUN]) begin
            overrun_r <= 1'b0;
         end
      end
   end

   // Sample set capture with delayed counter beside the analog words
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         set_r <= '0;
      end else if (take_set) begin
         set_r.ain <= adc_set_in.ain;
         set_r.cnt <= cnt_delayed; // [RULE14]
      end
   end

   // Serialiser; a set arriving while one is still pending replaces it
   always_ff @(posedge mclk_in) begin
      if (rst_in || !run_r) begin
         pend_r <= '0;
         stream_valid_out <= 1'b0;
         stream_data_out <= '0;
         stream_last_out <= 1'b0;
      end else if (take_set) begin
         pend_r <= eff_mask(mask_r);
         stream_valid_out <= 1'b0;
         stream_last_out <= 1'b0;
      end else if (!stream_valid_out || stream_ready_in) begin
         if (pend_r != '0) begin
            stream_valid_out <= 1'b1;
            stream_data_out <= (next_ch == CHW'(sac_pkg::N_AIN)) ?
               set_r.cnt : set_r.ain[next_ch[1:0]]; // [RULE20]
            stream_last_out <= rest == '0;
            pend_r <= rest;
         end else begin
            stream_valid_out <= 1'b0;
            stream_last_out <= 1'b0;
         end
      end
   end

   // Register read mux
   always_comb begin
      rdata = '0;
      mapped = 1'b1;
      unique case (paddr_in)
         sac_pkg::OFS_CTRL: begin
            rdata[sac_pkg::CTRL_GAIN] = fe_out.gain10;
            rdata[sac_pkg::CTRL_HIPWR] = fe_out.hipower;
            rdata[sac_pkg::CTRL_RUN] = run_r;
            rdata[sac_pkg::CTRL_MASK_LSB +: NCH] = mask_r;
         end
         sac_pkg::OFS_FE: begin
            rdata[sac_pkg::N_AIN-1:0] = fe_out.excite;
            rdata[sac_pkg::FE_AC_LSB +: sac_pkg::N_AIN] = fe_out.ac_couple;
         end
         sac_pkg::OFS_RATE: rdata[sac_pkg::RATE_W-1:0] = rate_r;
         sac_pkg::OFS_ACTUAL: rdata[sac_pkg::RATE_W-1:0] = actual; // [RULE12]
         sac_pkg::OFS_CMD: rdata = '0;
         sac_pkg::OFS_STATUS: begin
            rdata[sac_pkg::ST_BUSY] = sgl_r != SGL_IDLE;
            rdata[sac_pkg::ST_DONE] = done_r;
            rdata[sac_pkg::ST_GD_DONE] = gd_done;
            rdata[sac_pkg::ST_OVERRUN] = overrun_r;
            rdata[sac_pkg::ST_RUN] = run_r;
         end
         default: begin
            if (paddr_in >= sac_pkg::OFS_RESULT0
                && paddr_in <= sac_pkg::OFS_RESULT4
                && paddr_in[1:0] == 2'h0) begin
               rdata[sac_pkg::DATA_W-1:0] =
                  result_r[3'((paddr_in - sac_pkg::OFS_RESULT0) >> 2)];
            end else begin
               mapped = 1'b0;
            end
         end
      endcase
   end

   // Zero-wait APB answer registered during the setup cycle
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         prdata_out <= '0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !mapped;
         prdata_out <= (rd_en && !penable_in) ? rdata : '0;
      end
   end
endmodule

// [bench/sac_ctrl_properties.sv]
// Port checker for the sampling control block.
// Bound to sac_ctrl from the bench top; one clock domain.
`timescale 1ns/1ps
module sac_ctrl_properties (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // APB
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Converter side
   input wire logic adc_valid_in,
   input wire sac_pkg::sac_set_s adc_set_in,
   input wire sac_pkg::sac_fe_s fe_out,
   input wire logic tb_tick_out,
   input wire logic sample_tick_out,
   input wire logic single_req_out,
   // Stream
   input wire logic stream_ready_in,
   input wire logic stream_valid_out,
   input wire logic [sac_pkg::DATA_W-1:0] stream_data_out,
   input wire logic stream_last_out
);
   logic run_r;
   logic [5:0] gd_r;
   wire logic wr_acc = psel_in && penable_in && pwrite_in;
   default clocking dc @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   // Run shadow snooped from the bus
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         run_r <= 1'b0;
      end else if (wr_acc && paddr_in == sac_pkg::OFS_CTRL) begin
         run_r <= pwdata_in[sac_pkg::CTRL_RUN];
      end
   end
   // Ticks since run rose
   always_ff @(posedge mclk_in) begin
      if (rst_in || !run_r) begin
         gd_r <= 6'h00;
      end else if (sample_tick_out && gd_r != 6'h3F) begin
         gd_r <= gd_r + 6'h01;
      end
   end
   AST_READY: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready");
   AST_ERR: assert property (pslverr_out |-> pready_out && penable_in)
      else $error("late err");
   AST_EXC_OFF: assert property ($fell(rst_in) |-> fe_out == '0)
      else $error("fe on");
   AST_TB_MAX: assert property (tb_tick_out |=> !tb_tick_out [*2])
      else $error("tb fast");
   AST_FE_CTRL: assert property (wr_acc && paddr_in == sac_pkg::OFS_CTRL |=>
      fe_out.gain10 == $past(pwdata_in[sac_pkg::CTRL_GAIN]) &&
      fe_out.hipower == $past(pwdata_in[sac_pkg::CTRL_HIPWR]))
      else $error("ctrl fe");
   AST_FE_IN: assert property (wr_acc && paddr_in == sac_pkg::OFS_FE |=>
      fe_out.excite == $past(pwdata_in[3:0]) &&
      fe_out.ac_couple == $past(pwdata_in[11:8]))
      else $error("input fe");
   AST_SINGLE: assert property (single_req_out |->
      $past(wr_acc && paddr_in == sac_pkg::OFS_CMD && !run_r))
      else $error("stray req");
   AST_SINGLE_GAP: assert property (single_req_out |=> !single_req_out [*2])
      else $error("req again");
   AST_GD: assert property ($rose(stream_valid_out) |-> gd_r >= 6'h27)
      else $error("early data");
   AST_HOLD: assert property (stream_valid_out && !stream_ready_in &&
      !adc_valid_in |=> stream_valid_out && $stable(stream_data_out))
      else $error("word lost");
   AST_CAPTURE: assert property ($rose(stream_valid_out) |->
      $past(adc_valid_in, 2))
      else $error("stray word");
   cover property (single_req_out);
   cover property (pslverr_out);
   cover property (stream_valid_out && stream_ready_in && stream_last_out);
endmodule

// [bench/sac_adc_model.sv]
// Converter model: answers each sample tick or single request with a set.
// Sets carry the tick count to trace their origin.
`timescale 1ns/1ps
module sac_adc_model #(
   parameter int DLY = 20
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Requests
   input wire logic sample_tick_in,
   input wire logic single_req_in,
   // Results
   output logic adc_valid_out,
   output sac_pkg::sac_set_s adc_set_out
);
   logic [15:0] tick_r;
   logic [7:0] wait_r;
   sac_pkg::sac_set_s set_now;
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         tick_r <= 16'h0000;
      end else if (sample_tick_in) begin
         tick_r <= tick_r + 16'h0001;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wait_r <= 8'h00;
      end else if (sample_tick_in || single_req_in) begin
         wait_r <= 8'(DLY);
      end else if (wait_r != 8'h00) begin
         wait_r <= wait_r - 8'h01;
      end
   end
   always_ff @(posedge mclk_in) begin
      adc_valid_out <= !rst_in && wait_r == 8'h01;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         set_now.ain[i] = {4'(i + 1), 4'h0, tick_r};
      end
      set_now.cnt = {8'h5A, tick_r};
   end
   // Floating lines read as inverse
   assign adc_set_out = adc_valid_out ? set_now : ~set_now;
endmodule

// [bench/tb_top.sv]
// Bench for the sampling control block.
// Drives APB and the stream sink.
`timescale 1ns/1ps
module tb_top;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic stream_ready_in = 1'b0;
   logic [31:0] prdata_out, q;
   logic pready_out, pslverr_out, e, l;
   logic adc_valid_in, tb_tick_out, sample_tick_out, single_req_out;
   logic stream_valid_out, stream_last_out;
   logic [23:0] stream_data_out, d;
   logic [15:0] k0;
   sac_pkg::sac_set_s adc_set_in;
   sac_pkg::sac_fe_s fe_out;
   int n_mismatch = 0;
   int n_compared = 0;
   sac_ctrl #(.RATE_MAX(sac_pkg::RATE_MAX_HI), .COUNTER_VARIANT(1'b1))
      u_dut (.*);
   sac_adc_model u_adc (
      .mclk_in(mclk_in), .rst_in(rst_in), .sample_tick_in(sample_tick_out),
      .single_req_in(single_req_out), .adc_valid_out(adc_valid_in),
      .adc_set_out(adc_set_in)
   );
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   task report_and_stop;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task to_fail;
      n_mismatch++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
   endtask
   task cmp(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      int k;
      k = 0;
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      @(posedge mclk_in);
      while (pready_out !== 1'b1 && k < 20) begin
         @(posedge mclk_in);
         k++;
      end
      if (k >= 20) begin
         to_fail();
      end
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      cmp(q, x);
   endtask
   task wait_done;
      int k;
      k = 0;
      q = 32'h0;
      while (q[sac_pkg::ST_DONE] !== 1'b1 && k < 100) begin
         apb(1'b0, sac_pkg::OFS_STATUS, 32'h0);
         k++;
      end
      if (q[sac_pkg::ST_DONE] !== 1'b1) begin
         to_fail();
      end
   endtask
   task tick_span(input logic [31:0] x);
      int k, n;
      k = 0;
      n = 0;
      while (sample_tick_out !== 1'b1 && k < 5000) begin
         @(posedge mclk_in);
         k++;
      end
      @(posedge mclk_in);
      while (sample_tick_out !== 1'b1 && k < 5000) begin
         n += (tb_tick_out === 1'b1);
         @(posedge mclk_in);
         k++;
      end
      n += (tb_tick_out === 1'b1);
      if (k >= 5000) begin
         to_fail();
      end
      cmp(32'(n), x);
   endtask
   // Sink stalls two cycles per word
   task take;
      int k;
      k = 0;
      while (stream_valid_out !== 1'b1 && k < 60000) begin
         @(posedge mclk_in);
         k++;
      end
      if (k >= 60000) begin
         to_fail();
      end
      repeat (2) @(posedge mclk_in);
      stream_ready_in <= 1'b1;
      @(posedge mclk_in);
      d = stream_data_out;
      l = stream_last_out;
      stream_ready_in <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      cmp(32'(fe_out), 32'h0);
      rd(sac_pkg::OFS_RATE, 32'h0002_FAE4);
      rd(sac_pkg::OFS_STATUS, 32'h0);
      apb(1'b0, 8'h3C, 32'h0);
      cmp({q[30:0], e}, 32'h1);
      for (int i = 0; i < 2; i++) begin
         d = (i == 0) ? 24'h000505 : 24'h000A0A;
         apb(1'b1, sac_pkg::OFS_FE, {8'h0, d});
         rd(sac_pkg::OFS_FE, {8'h0, d});
         cmp(32'(fe_out), {24'h0, d[3:0], d[11:8]});
      end
      apb(1'b1, sac_pkg::OFS_CTRL, 32'h2);
      cmp(32'(fe_out[9:8]), 32'h1);
      apb(1'b1, sac_pkg::OFS_CMD, 32'h0000_0121);
      apb(1'b1, sac_pkg::OFS_CMD, 32'h0000_0011);
      rd(sac_pkg::OFS_STATUS, 32'h1);
      wait_done();
      rd(sac_pkg::OFS_RESULT0 + 8'h08, 32'h0030_0000);
      rd(sac_pkg::OFS_RESULT0 + 8'h04, 32'h0);
      rd(sac_pkg::OFS_RESULT4, 32'h0);
      rd(sac_pkg::OFS_CTRL, 32'h3);
      apb(1'b1, sac_pkg::OFS_STATUS, 32'h2);
      rd(sac_pkg::OFS_STATUS, 32'h0);
      apb(1'b1, sac_pkg::OFS_CMD, 32'h3);
      wait_done();
      for (int i = 0; i < 5; i++) begin
         q = (i < 4) ? {8'h0, 4'(i + 1), 20'h0} : 32'h005A_0000;
         rd(sac_pkg::OFS_RESULT0 + 8'(4 * i), q);
      end
      apb(1'b1, sac_pkg::OFS_RATE, 32'h0);
      rd(sac_pkg::OFS_RATE, 32'h0);
      apb(1'b1, sac_pkg::OFS_RATE, 32'h07FF_FFFF);
      rd(sac_pkg::OFS_RATE, 32'h07FF_FFFF);
      rd(sac_pkg::OFS_ACTUAL, 32'h0649_534E);
      apb(1'b1, sac_pkg::OFS_RATE, {5'h0, sac_pkg::RATE_MAX_LO});
      rd(sac_pkg::OFS_ACTUAL, {5'h0, sac_pkg::RATE_MAX_LO});
      apb(1'b1, sac_pkg::OFS_CTRL, 32'h4);
      tick_span(32'd512);
      apb(1'b1, sac_pkg::OFS_CTRL, 32'h0);
      apb(1'b1, sac_pkg::OFS_RATE, 32'h07FF_FFFF);
      apb(1'b1, sac_pkg::OFS_CTRL, 32'h154);
      tick_span(32'd256);
      take();
      k0 = d[15:0];
      cmp({23'h0, d[23:16], l}, 32'h20);
      take();
      cmp({7'h0, l, d}, {8'h0, 8'h30, k0});
      take();
      cmp({23'h0, d[23:16], l}, 32'hB5);
      cmp(32'(k0 - d[15:0]), 32'h26);
      apb(1'b1, sac_pkg::OFS_CTRL, 32'h0);
      report_and_stop();
   end
endmodule
bind sac_ctrl sac_ctrl_properties u_props (.*);
